/* File: creh_consts.svh */
// Constants for the CAN receive error handling block
`ifndef CREH_CONSTS_SVH
`define CREH_CONSTS_SVH

// Register byte addresses
`define CREH_ADDR_STATUS 8'h00
`define CREH_ADDR_REC    8'h04
`define CREH_ADDR_BUFREL 8'h08

// Status register bit positions
`define CREH_ST_SUMMARY  0
`define CREH_ST_INVALID  1
`define CREH_ST_WARN     2
`define CREH_ST_PASSIVE  3
`define CREH_ST_RCV_LO   4
`define CREH_ST_OVR_LO   6

// Reset values
`define CREH_REC_RST     8'h00
`define CREH_FLAGS_RST   2'h0

// Error counter limits
`define CREH_REC_MAX     8'hFF
`define CREH_REC_WARN    8'h60
`define CREH_REC_PASSIVE 8'h7F
`define CREH_REC_RESTORE 8'h7F
`define CREH_REC_INC1    8'h01
`define CREH_REC_INC8    8'h08

// Dominant bit run limits after an error flag
`define CREH_DOM_ACTIVE  5'h0E
`define CREH_DOM_PASSIVE 5'h08
`define CREH_DOM_STEP    5'h08
`define CREH_ACT_FLAG    5'h06

// Bit stuffing and CRC
`define CREH_STUFF_RUN   3'h6
`define CREH_CRC_POLY    15'h4599
`define CREH_CRC_RST     15'h0000

`endif

/* File: creh_pkg.sv */
// Types for the CAN receive error handling block
package creh_pkg;

  // Bit and frame events from the protocol engine, same clock
  typedef struct packed {
    logic bit_stb;
    logic bit_val;
    logic stuff_bit;
    logic sof;
    logic crc_cov;
    logic crc_fld;
    logic stf_zone;
    logic crc_chk;
    logic ack_ok;
    logic eof_ok;
    logic acc;
    logic tgt;
    logic other_err;
    logic flag_start;
    logic flag_passive;
    logic flag_end;
    logic flag_bit_err;
    logic tx_node;
  } creh_evt_type;

  // Actions handed back to the protocol engine
  typedef struct packed {
    logic err_frame;
    logic store;
    logic store_idx;
    logic tec_add8;
  } creh_act_type;

  typedef enum logic [1:0] {
    CREH_IDLE  = 2'b00,
    CREH_FLAG  = 2'b01,
    CREH_FIRST = 2'b11,
    CREH_RUN   = 2'b10
  } creh_st_type;

endpackage

/* File: creh_rx_err.sv */
// CAN receive error detection, error counter and status flags
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// [R1] Reset clears all state, discards message
// [R2] CRC mismatch flags error, sends error frame
// [R3] Six equal bits is stuff error
// [R4] Any receive error sets invalid-message flag
// [R5] Receiver error adds one to counter
// [R6] Dominant first bit after flag adds eight
// [R7] Bit error in active flag adds eight
// [R8] Long dominant runs after flag add eight
// [R9] Good reception decrements or restores counter
// [R10] Received flag set after end of frame
// [R11] One summary flag set by error conditions
// [R12] Full buffer: overrun flag, message discarded
// [R13] Warning bit at 96, rise sets summary
// [R14] Warning cleared by hardware at 95
// [R15] Clearing summary leaves status bits alone
// [R16] Passive bit above 127, rise sets summary
// [R17] Passive cleared by hardware at 127
// [R18] CRC and stuff errors raise no interrupt
// [R19] Software may use invalid flag for baud
// [R20] Eight-bit counter saturates, never wraps
`include "creh_consts.svh"

module creh_rx_err
  import creh_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire creh_evt_type evt,
  output creh_act_type      act,
  output logic              err_passive
);

  function automatic logic addr_is(
    input logic [7:0] a,
    input logic [7:0] o
  );
    return a == o;
  endfunction

  function automatic logic [14:0] crc_step(
    input logic [14:0] c,
    input logic        b
  );
    logic [14:0] s;
    s = {c[13:0], 1'b0};
    if (b ^ c[14]) begin
      s = s ^ `CREH_CRC_POLY;
    end
    return s;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  //////////////////////////////////////////////////////////////////////
  // CRC check

  logic [14:0] crc_calc_r;
  logic [14:0] crc_rx_r;
  logic        data_bit;
  logic        crc_err;

  assign data_bit = evt.bit_stb & ~evt.stuff_bit;
  assign crc_err  = evt.crc_chk & (crc_calc_r != crc_rx_r); // [R2]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_calc_r <= `CREH_CRC_RST;
      crc_rx_r   <= `CREH_CRC_RST;
    end else if (evt.sof) begin
      crc_calc_r <= crc_step(`CREH_CRC_RST, evt.bit_val);
      crc_rx_r   <= `CREH_CRC_RST;
    end else begin
      if (data_bit && evt.crc_cov) begin
        crc_calc_r <= crc_step(crc_calc_r, evt.bit_val); // [R2]
      end
      if (data_bit && evt.crc_fld) begin
        crc_rx_r <= {crc_rx_r[13:0], evt.bit_val};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Stuffing check

  // Counts raw bits, stuff bits included, so a missing stuff bit shows
  logic [2:0] same_r;
  logic       last_r;
  logic       same_bit;
  logic [2:0] same_nxt;
  logic       stf_err;

  assign same_bit = evt.bit_val == last_r;
  assign same_nxt = same_bit ? same_r + 3'h1 : 3'h1;
  // The SOF bit opens a new run, so it never ends an old one
  assign stf_err  = evt.bit_stb & evt.stf_zone & same_bit & ~evt.sof
                  & (same_nxt == `CREH_STUFF_RUN); // [R3]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      same_r <= 3'h0;
      last_r <= 1'b1;
    end else if (evt.bit_stb && evt.stf_zone) begin
      same_r <= evt.sof ? 3'h1 : same_nxt;
      last_r <= evt.bit_val;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Dominant bits after an error flag

  creh_st_type st_r;
  creh_st_type st_nxt;
  logic [4:0]  dom_r;
  logic [4:0]  dom_nxt;
  logic [4:0]  lim_r;
  logic [4:0]  lim_nxt;
  logic        pflag_r;
  logic        pflag_nxt;
  logic        first_dom;
  logic        run_hit;

  always_comb begin
    st_nxt    = st_r;
    dom_nxt   = dom_r;
    lim_nxt   = lim_r;
    pflag_nxt = pflag_r;
    first_dom = 1'b0;
    run_hit   = 1'b0;
    if (evt.flag_start) begin
      st_nxt    = CREH_FLAG;
      pflag_nxt = evt.flag_passive;
      lim_nxt   = evt.flag_passive ? `CREH_DOM_PASSIVE
                                   : `CREH_DOM_ACTIVE;
    end else begin
      unique case (st_r)
        CREH_IDLE: begin
          st_nxt = CREH_IDLE;
        end
        CREH_FLAG: begin
          if (evt.flag_end) begin
            st_nxt  = CREH_FIRST;
            // Active flag bits count toward the run
            dom_nxt = pflag_r ? 5'h00 : `CREH_ACT_FLAG;
          end
        end
        CREH_FIRST: begin
          if (evt.bit_stb) begin
            if (!evt.bit_val) begin
              first_dom = 1'b1; // [R6]
              dom_nxt   = dom_r + 5'h01;
              st_nxt    = CREH_RUN;
            end else begin
              st_nxt = CREH_IDLE;
            end
          end
        end
        CREH_RUN: begin
          if (evt.bit_stb) begin
            if (evt.bit_val) begin
              st_nxt = CREH_IDLE;
            end else if (dom_r + 5'h01 == lim_r) begin
              run_hit = 1'b1; // [R8]
              dom_nxt = 5'h00;
              lim_nxt = `CREH_DOM_STEP;
            end else begin
              dom_nxt = dom_r + 5'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= CREH_IDLE;
      dom_r   <= 5'h00;
      lim_r   <= `CREH_DOM_ACTIVE;
      pflag_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      dom_r   <= dom_nxt;
      lim_r   <= lim_nxt;
      pflag_r <= pflag_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Receive error counter

  logic [7:0] rec_r;
  logic [7:0] rec_nxt;
  logic [7:0] rec_add;
  logic [8:0] rec_sum;
  logic       err_now;
  logic       add8;
  logic       frm_err_r;
  logic       good_rx;

  assign err_now = crc_err | stf_err | evt.other_err; // [R5]
  assign add8    = evt.flag_bit_err | first_dom
                 | (run_hit & ~evt.tx_node); // [R7] [R8]
  assign rec_add = add8 ? `CREH_REC_INC8 : `CREH_REC_INC1;
  assign rec_sum = {1'b0, rec_r} + {1'b0, rec_add};
  assign good_rx = evt.ack_ok & ~frm_err_r & ~err_now;

  always_comb begin
    rec_nxt = rec_r;
    if (add8 || err_now) begin
      rec_nxt = rec_sum[8] ? `CREH_REC_MAX : rec_sum[7:0]; // [R20]
    end else if (good_rx) begin
      if (rec_r > `CREH_REC_PASSIVE) begin
        rec_nxt = `CREH_REC_RESTORE; // [R9]
      end else if (rec_r != 8'h00) begin
        rec_nxt = rec_r - 8'h01; // [R9]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_r     <= `CREH_REC_RST; // [R1]
      frm_err_r <= 1'b0;
    end else begin
      rec_r     <= rec_nxt;
      frm_err_r <= ~evt.sof & (frm_err_r | err_now
                 | evt.flag_start);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status flags

  logic       warn_r;
  logic       pas_r;
  logic       warn_nxt;
  logic       pas_nxt;
  logic       sum_r;
  logic       inv_r;
  logic [1:0] rcv_r;
  logic [1:0] ovr_r;
  logic [1:0] full_r;
  logic [1:0] tgt_dec;
  logic       msg_in;
  logic       ovr_hit;
  logic [1:0] ovr_set;
  logic [1:0] rcv_set;
  logic       sum_set;
  logic       inv_set;

  assign warn_nxt = rec_nxt >= `CREH_REC_WARN; // [R13] [R14]
  assign pas_nxt  = rec_nxt > `CREH_REC_PASSIVE; // [R16] [R17]
  assign tgt_dec  = evt.tgt ? 2'b10 : 2'b01;
  assign msg_in   = evt.eof_ok & evt.acc;
  assign ovr_hit  = msg_in & |(full_r & tgt_dec); // [R12]
  assign ovr_set  = ovr_hit ? tgt_dec : 2'b00; // [R12]
  assign rcv_set  = (msg_in & ~ovr_hit) ? tgt_dec : 2'b00; // [R10]
  // Counter errors reach the summary only through thresholds
  assign sum_set  = (warn_nxt & ~warn_r) | (pas_nxt & ~pas_r)
                  | ovr_hit; // [R11] [R13] [R16] [R18]
  assign inv_set  = err_now | evt.flag_bit_err; // [R4]

  //////////////////////////////////////////////////////////////////////
  // APB slave

  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        apb_acc;
  logic        wr_stb;
  logic        hit_st;
  logic        hit_rec;
  logic        hit_rel;
  logic        hit_any;
  logic [31:0] rd_mux;
  logic [31:0] st_word;
  logic [31:0] clr_st;
  logic [1:0]  rel;

  assign apb_acc = psel & penable & ~pready_r;
  assign wr_stb  = psel & penable & pready_r & pwrite;
  assign hit_st  = addr_is(paddr, `CREH_ADDR_STATUS);
  assign hit_rec = addr_is(paddr, `CREH_ADDR_REC);
  assign hit_rel = addr_is(paddr, `CREH_ADDR_BUFREL);
  assign hit_any = hit_st | hit_rec | hit_rel;
  assign st_word = {24'h000000, ovr_r, rcv_r, pas_r, warn_r,
                    inv_r, sum_r};
  assign rd_mux  = hit_st  ? st_word
                 : hit_rec ? {24'h000000, rec_r}
                 : hit_rel ? {30'h00000000, full_r}
                 : 32'h00000000;
  // Warning and passive bits have no clear path
  assign clr_st  = (wr_stb & hit_st) ? pwdata
                 : 32'h00000000; // [R14] [R15] [R17]
  assign rel     = (wr_stb & hit_rel) ? pwdata[1:0] : 2'b00;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= apb_acc;
      pslverr_r <= apb_acc & ~hit_any;
      prdata_r  <= (apb_acc & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Flag registers: a set in the clear cycle wins

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_r <= 1'b0;
      pas_r  <= 1'b0;
      sum_r  <= 1'b0;
      inv_r  <= 1'b0;
      rcv_r  <= `CREH_FLAGS_RST;
      ovr_r  <= `CREH_FLAGS_RST;
      full_r <= `CREH_FLAGS_RST; // [R1]
    end else begin
      warn_r <= warn_nxt; // [R13] [R14]
      pas_r  <= pas_nxt; // [R16] [R17]
      sum_r  <= (sum_r & ~clr_st[`CREH_ST_SUMMARY])
              | sum_set; // [R11] [R15]
      inv_r  <= (inv_r & ~clr_st[`CREH_ST_INVALID])
              | inv_set; // [R4]
      rcv_r  <= (rcv_r & ~clr_st[`CREH_ST_RCV_LO +: 2])
              | rcv_set; // [R10]
      ovr_r  <= (ovr_r & ~clr_st[`CREH_ST_OVR_LO +: 2])
              | ovr_set; // [R12]
      full_r <= (full_r & ~rel) | rcv_set;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Actions toward the protocol engine

  creh_act_type act_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= '0;
    end else begin
      act_r.err_frame <= crc_err | stf_err; // [R2] [R3]
      act_r.store     <= msg_in & ~ovr_hit; // [R12]
      act_r.store_idx <= evt.tgt;
      act_r.tec_add8  <= run_hit & evt.tx_node; // [R8]
    end
  end

  assign act         = act_r;
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign err_passive = pas_r;

endmodule

/* File: creh_rx_err_sva.sv */
// Port assertions for the receive error handling block
`timescale 1ns/1ps
module creh_rx_err_sva
  import creh_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         arst_n,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire creh_evt_type evt,
  input wire creh_act_type act,
  input wire logic         err_passive
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////
  sequence s_eof0;
    evt.eof_ok && evt.acc && !evt.tgt;
  endsequence
  sequence s_rec_rd;
    pready && !pwrite && paddr == 8'h04;
  endsequence
  property p_rst;
    $rose(arst_n) |-> (!err_passive && !act.store)[*2];
  endproperty
  property p_store_src;
    act.store |-> $past(evt.eof_ok && evt.acc);
  endproperty
  property p_store_idx;
    act.store |-> act.store_idx == $past(evt.tgt);
  endproperty
  // Second message to a just-filled buffer must be dropped
  property p_ovr;
    s_eof0 ##1 s_eof0 |=> !(act.store && !act.store_idx);
  endproperty
  property p_errfr;
    act.err_frame |-> $past(evt.crc_chk || evt.bit_stb && evt.stf_zone);
  endproperty
  property p_tec;
    act.tec_add8 |-> $past(evt.bit_stb && !evt.bit_val && evt.tx_node);
  endproperty
  // Skip reads that straddle a change of the passive level
  property p_ep_rec;
    s_rec_rd ##0 $stable(err_passive) |->
      err_passive == (prdata[7:0] > 8'h7F);
  endproperty
  property p_rec_hi;
    s_rec_rd |-> prdata[31:8] == 24'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active right after reset");
  a_store_src: assert property (p_store_src)
    else $error("store without accepted end of frame");
  a_store_idx: assert property (p_store_idx)
    else $error("store to wrong buffer");
  a_ovr: assert property (p_ovr)
    else $error("message stored into a full buffer");
  a_errfr: assert property (p_errfr)
    else $error("error frame without a cause");
  a_tec: assert property (p_tec)
    else $error("transmit count step without dominant bit");
  a_ep_rec: assert property (p_ep_rec)
    else $error("passive level disagrees with counter");
  a_rec_hi: assert property (p_rec_hi)
    else $error("counter wider than eight bits");
endmodule
bind creh_rx_err creh_rx_err_sva creh_rx_err_sva_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .evt(evt), .act(act),
  .err_passive(err_passive)
);

/* File: creh_can_node.sv */
// Model of the bus side: bit and frame events from other nodes
`timescale 1ns/1ps
module creh_can_node
  import creh_pkg::*;
(
  input wire logic         ref_clk,
  output creh_evt_type     evt
);
  logic tx = 1'b0;
  initial evt = '0;
  //////////////////////////////////////////////////////////////////////
  // Quiet cycle after each event so pulses never merge by accident
  task ev(input creh_evt_type x, input int n = 1);
    creh_evt_type y;
    y = x;
    y.tx_node = tx;
    @(posedge ref_clk);
    evt <= y;
    repeat (n) @(posedge ref_clk);
    y = '0;
    y.tx_node = tx;
    evt <= y;
  endtask
  task bitv(input logic v, input logic s, input logic z);
    creh_evt_type x;
    x = '0;
    x.bit_stb = 1'b1;
    x.bit_val = v;
    x.sof = s;
    x.stf_zone = z;
    x.crc_cov = z;
    ev(x);
  endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the receive error handling block
`timescale 1ns/1ps
`include "creh_consts.svh"
module tb_top
  import creh_pkg::*;
;
  logic         ref_clk;
  logic         arst_n;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  creh_evt_type evt;
  creh_act_type act;
  logic         err_passive;
  logic [31:0]  q;
  logic         e;
  int           errors = 0;
  int           tests_run = 0;
  int           nfr = 0;
  int           ntec = 0;
  int           nst = 0;
  // Dominant SOF leaves zero, one recessive bit then leaves the generator
  localparam logic [14:0] crc_exp = `CREH_CRC_POLY;
  creh_rx_err creh_rx_err_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .act(act),
    .err_passive(err_passive)
  );
  creh_can_node creh_can_node_inst (.ref_clk(ref_clk), .evt(evt));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (act.err_frame === 1'b1) nfr++;
    if (act.tec_add8 === 1'b1) ntec++;
    if (act.store === 1'b1) nst++;
  end
  //////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, q);
    chk("slverr", {31'h0, a > 8'h08}, {31'h0, e});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task p(input creh_evt_type x, input int n = 1);
    creh_can_node_inst.ev(x, n);
  endtask
  // Start of frame then a clean acknowledge
  task frame;
    creh_can_node_inst.bitv(1'b0, 1'b1, 1'b1);
    p('{default:0, ack_ok:1});
  endtask
  task summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize;
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(8'h00, 32'h0, "status");
    rd(8'h04, 32'h0, "rec");
    rd(8'h0C, 32'h0, "unmapped");
    repeat (96) p('{default:0, other_err:1});
    rd(8'h04, 32'h60, "rec");
    rd(8'h00, 32'h07, "status");
    wr(8'h00, 32'h0F);
    rd(8'h00, 32'h04, "status");
    frame;
    rd(8'h04, 32'h5F, "rec");
    rd(8'h00, 32'h00, "status");
    p('{default:0, flag_start:1});
    p('{default:0, flag_end:1});
    creh_can_node_inst.bitv(1'b0, 1'b0, 1'b0);
    creh_can_node_inst.bitv(1'b1, 1'b0, 1'b0);
    rd(8'h04, 32'h67, "rec");
    rd(8'h00, 32'h05, "status");
    repeat (4) p('{default:0, flag_bit_err:1});
    rd(8'h04, 32'h87, "rec");
    chk("err_passive", 32'h1, {31'h0, err_passive});
    frame;
    rd(8'h04, 32'h7F, "rec");
    chk("err_passive", 32'h0, {31'h0, err_passive});
    wr(8'h00, 32'hFF);
    rd(8'h00, 32'h04, "status");
    creh_can_node_inst.bitv(1'b0, 1'b1, 1'b1);
    repeat (5) creh_can_node_inst.bitv(1'b0, 1'b0, 1'b1);
    rd(8'h04, 32'h80, "rec");
    chk("err_frames", 32'h1, nfr);
    rd(8'h00, 32'h0F, "status");
    repeat (20) p('{default:0, flag_bit_err:1});
    rd(8'h04, 32'hFF, "rec");
    wr(8'h00, 32'hFF);
    p('{default:0, eof_ok:1, acc:1}, 2);
    rd(8'h00, 32'h5D, "status");
    rd(8'h08, 32'h1, "full");
    p('{default:0, eof_ok:1, acc:1, tgt:1});
    rd(8'h08, 32'h3, "full");
    chk("stores", 32'h2, nst);
    wr(8'h08, 32'h3);
    rd(8'h08, 32'h0, "full");
    creh_can_node_inst.tx = 1'b1;
    p('{default:0, flag_start:1, flag_passive:1});
    p('{default:0, flag_end:1});
    repeat (8) creh_can_node_inst.bitv(1'b0, 1'b0, 1'b0);
    creh_can_node_inst.tx = 1'b0;
    // The step pulse leaves one cycle after the eighth bit
    repeat (2) @(posedge ref_clk);
    chk("tec_steps", 32'h1, ntec);
    // Reset in mid-run with a stored message pending
    p('{default:0, eof_ok:1, acc:1});
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(8'h00, 32'h0, "status");
    rd(8'h04, 32'h0, "rec");
    rd(8'h08, 32'h0, "full");
    chk("err_passive", 32'h0, {31'h0, err_passive});
    // Matching check value; the stuff bit must not enter the sum
    creh_can_node_inst.bitv(1'b0, 1'b1, 1'b1);
    p('{default:0, bit_stb:1, bit_val:1, crc_cov:1});
    p('{default:0, bit_stb:1, stuff_bit:1, crc_cov:1});
    for (int i = 14; i >= 0; i--) begin
      p('{default:0, bit_stb:1, bit_val:crc_exp[i], crc_fld:1});
    end
    p('{default:0, crc_chk:1});
    p('{default:0, ack_ok:1});
    rd(8'h04, 32'h0, "rec");
    chk("err_frames", 32'h1, nfr);
    // Check field left at zero: mismatch
    creh_can_node_inst.bitv(1'b0, 1'b1, 1'b1);
    p('{default:0, bit_stb:1, bit_val:1, crc_cov:1});
    p('{default:0, crc_chk:1});
    rd(8'h04, 32'h1, "rec");
    chk("err_frames", 32'h2, nfr);
    rd(8'h00, 32'h02, "status");
    // Active flag: six flag bits plus eight, then eight more
    p('{default:0, flag_start:1});
    p('{default:0, flag_end:1});
    repeat (16) creh_can_node_inst.bitv(1'b0, 1'b0, 1'b0);
    creh_can_node_inst.bitv(1'b1, 1'b0, 1'b0);
    rd(8'h04, 32'h19, "rec");
    chk("tec_steps", 32'h1, ntec);
    summarize;
  end
endmodule
